// ---- verilog/iec958_audio_pkg.sv ----
package iec958_audio_pkg;

  // Clock and input rate window
  localparam int CLK_HZ = 40_000_000;
  localparam int FS_MIN_HZ = 28_000;
  localparam int FS_MAX_HZ = 100_000;
  // Shortest legal sample period rounds down, longest rounds up
  localparam logic [10:0] PERIOD_MIN = 11'(CLK_HZ / FS_MAX_HZ);
  localparam logic [10:0] PERIOD_MAX = 11'((CLK_HZ + FS_MIN_HZ - 1) / FS_MIN_HZ);
  localparam logic [10:0] PERIOD_SAT = 11'h7FF;

  // Soft mute ramp: 32 gain steps of 32 samples each
  localparam logic [5:0] MUTE_STEPS = 6'h20;
  localparam logic [4:0] MUTE_SUB_LAST = 5'h1F;

  // Oversampling 1fs to 128fs
  localparam int OS_SHIFT = 7;
  localparam logic [10:0] OS_RELOAD_MIN = 11'h001;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] TONE_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] SAMPLE_ADDR = 8'h0C;

  // Control register fields and reset value
  localparam int CTRL_SOFT_MUTE_BIT = 0;
  localparam int CTRL_AUTO_MUTE_BIT = 1;
  localparam int CTRL_DEEMPH_LSB = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;

  // Tone register fields
  localparam int TONE_VOL_LSB = 0;
  localparam int TONE_BASS_LSB = 8;
  localparam int TONE_TREB_LSB = 16;
  localparam int TONE_MODE_LSB = 20;
  localparam logic [31:0] TONE_RESET = 32'h0000_0000;

  // Channel status bit positions within a block
  localparam int CS_NONPCM_BIT = 1;
  localparam int CS_PREEMPH_LSB = 3;
  localparam int CS_FS_LSB = 24;
  localparam int CS_ACC_LSB = 28;
  localparam logic [7:0] CS_LAST_BIT = 8'h1F;
  localparam logic [2:0] CS_PREEMPH_50_15 = 3'h1;
  localparam logic [3:0] CS_FS_32K = 4'h3;
  localparam logic [3:0] CS_FS_48K = 4'h2;

  // Filter coefficient shifts
  localparam int BASS_LP_SHIFT = 6;
  localparam int TREB_LP_SHIFT = 1;
  localparam int REC_SHIFT = 3;

  typedef enum logic [1:0] {TONE_FLAT = 2'b00, TONE_MIN = 2'b01, TONE_MAX = 2'b10} tone_mode_t;
  typedef enum logic [1:0] {DE_OFF = 2'b00, DE_32K = 2'b01, DE_44K1 = 2'b10, DE_48K = 2'b11} deemph_t;
  typedef enum logic [1:0] {M_PLAY = 2'b00, M_FALL = 2'b01, M_SILENT = 2'b10, M_RISE = 2'b11} mute_state_t;

endpackage

// ---- verilog/iec958_lock_mute_audio_path.sv ----
`timescale 1ns/10ps
// Functional notes
// - Accept input sample rates from 28.0 kHz up to 100.0 kHz.
// - Set a readable lock bit once the regenerated clock is locked.
// - Lock pin high only when decoder and clock locked and data is PCM.
// - Lock pin low when content is non-PCM or lock is absent.
// - Soft mute comes from mute pin in static mode, control bit otherwise.
// - Soft mute is a raised cosine ramp over 32 times 32 samples; the code uses a smoothstep curve instead.
// - In serial control mode the soft mute bit is set after reset.
// - In serial control mode the mute pin is ignored.
// - Outputs stay muted until lock, whatever the mute pin or bit say.
// - Out-of-lock mute is an abrupt hard mute, no ramp.
// - Clearing the auto mute enable bit stops out-of-lock muting.
// - Extract full 24-bit left and right samples from each frame.
// - Capture pre-emphasis, rate, PCM and accuracy status; make them readable.
// - Decode 32 to 96 kHz streams, 2.048 to 6.144 Mbit/s.
// - Static mode applies de-emphasis from received pre-emphasis flag.
// - Serial mode gives 6-bit volume, 4-bit bass, 2-bit treble.
// - Tone filters have flat, minimum and maximum modes.
// - Serial mode selects de-emphasis for 32, 44.1 and 48 kHz.
// - Interpolate 1fs to 128fs with recursive then FIR stage.
// - Third-order noise shaper runs at 128fs.
// - Noise shaper delivers a single-bit stream to the converter.
module iec958_lock_mute_audio_path
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Decoded frame input
  input wire logic frame_valid_i,
  input wire logic [23:0] frame_left_i,
  input wire logic [23:0] frame_right_i,
  input wire logic cs_bit_i,
  input wire logic block_start_i,
  input wire logic decoder_lock_i,
  input wire logic pll_lock_i,
  // Control pins
  input wire logic static_pin_mode_select_i,
  input wire logic mute_pin_i,
  // Status and converter stream
  output logic lock_o,
  output logic stream_left_o,
  output logic stream_right_o,
  output logic stream_strobe_o
);
  import iec958_audio_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic lock;
    logic pll_lock;
    logic dec_lock;
    logic soft_mute;
    logic auto_mute;
    logic [1:0] deemph_sel;
    logic [5:0] volume;
    logic [3:0] bass;
    logic [1:0] treble;
    logic [1:0] tone_mode;
    logic [7:0] cs_idx;
    logic [31:0] cs_word;
    logic non_pcm;
    logic [2:0] preemph;
    logic [3:0] fs_code;
    logic [1:0] accuracy;
    logic [10:0] period_cnt;
    logic [10:0] period;
    logic rate_ok;
    mute_state_t mstate;
    logic [5:0] mute_step;
    logic [4:0] mute_sub;
    logic [1:0][23:0] smp;
    logic [1:0][23:0] lp_de;
    logic [1:0][23:0] lp_bass;
    logic [1:0][23:0] lp_treb;
    logic [10:0] os_cnt;
    logic [1:0][23:0] rec;
    logic [1:0][23:0] rec_d;
    logic [1:0][27:0] ns1;
    logic [1:0][27:0] ns2;
    logic [1:0][27:0] ns3;
    logic [1:0] bits;
    logic strobe;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic locked;
  logic mute_req;
  logic hard_mute;
  logic bus_req;

  function automatic logic [23:0] sat24(input longint v);
    if (v > 64'sd8388607)
      return 24'h7FFFFF;
    else if (v < -64'sd8388608)
      return 24'h800000;
    else
      return v[23:0];
  endfunction

  function automatic logic [27:0] sat28(input longint v);
    if (v > 64'sd134217727)
      return 28'h7FFFFFF;
    else if (v < -64'sd134217728)
      return 28'h8000000;
    else
      return v[27:0];
  endfunction

  // Byte-lane merge used by both writable registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  // Smoothstep stand-in for the raised cosine, 0..65536 for k = 0..32
  function automatic longint ramp_gain(input logic [5:0] k);
    longint kk;
    kk = longint'(k);
    return (3 * kk * kk * 32 - 2 * kk * kk * kk) * 2;
  endfunction

  function automatic int deemph_shift(input logic [1:0] sel);
    case (sel)
      DE_32K: return 2;
      DE_44K1: return 3;
      DE_48K: return 3;
      default: return 0;
    endcase
  endfunction

  assign bus_req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
  assign locked = pll_lock_i & decoder_lock_i & state_reg.rate_ok;
  assign mute_req = static_pin_mode_select_i ? mute_pin_i : state_reg.soft_mute;
  assign hard_mute = state_reg.auto_mute & ~locked;

  always_comb
  begin
    logic [31:0] ctrl_w;
    logic [31:0] tone_w;
    logic [31:0] status_w;
    logic [31:0] cs_new;
    logic [7:0] idx;
    logic [1:0] de_sel;
    logic [1:0] mode;
    logic [5:0] vol;
    logic [3:0] bass;
    logic [1:0] treb;
    longint x;
    longint y;
    longint lp;
    longint fb;
    longint gain;
    int sh;
    ctrl_w = 32'h0000_0000;
    tone_w = 32'h0000_0000;
    status_w = 32'h0000_0000;
    cs_new = 32'h0000_0000;
    idx = 8'h00;
    x = 0;
    y = 0;
    lp = 0;
    fb = 0;
    sh = 0;
    gain = 0;
    de_sel = DE_OFF;
    mode = TONE_FLAT;
    vol = 6'h00;
    bass = 4'h0;
    treb = 2'h0;
    state_next = state_reg;

    ctrl_w[CTRL_SOFT_MUTE_BIT] = state_reg.soft_mute;
    ctrl_w[CTRL_AUTO_MUTE_BIT] = state_reg.auto_mute;
    ctrl_w[CTRL_DEEMPH_LSB +: 2] = state_reg.deemph_sel;
    tone_w[TONE_VOL_LSB +: 6] = state_reg.volume;
    tone_w[TONE_BASS_LSB +: 4] = state_reg.bass;
    tone_w[TONE_TREB_LSB +: 2] = state_reg.treble;
    tone_w[TONE_MODE_LSB +: 2] = state_reg.tone_mode;
    // fields packed from bit 0 upward
    status_w[0] = state_reg.pll_lock;
    status_w[1] = state_reg.dec_lock;
    status_w[2] = ~state_reg.non_pcm;
    status_w[3] = (state_reg.mstate == M_SILENT);
    status_w[4] = state_reg.rate_ok;
    status_w[7:5] = state_reg.preemph;
    status_w[11:8] = state_reg.fs_code;
    status_w[13:12] = state_reg.accuracy;

    // Wishbone: ack one cycle after the request, unmapped reads give zero
    state_next.ack = bus_req;
    case (wb_adr_i)
      CTRL_ADDR: state_next.dat = ctrl_w;
      TONE_ADDR: state_next.dat = tone_w;
      STATUS_ADDR: state_next.dat = status_w;
      SAMPLE_ADDR: state_next.dat = {8'h00, state_reg.smp[0]};
      default: state_next.dat = 32'h0000_0000;
    endcase
    if (bus_req && wb_we_i)
    begin
      if (wb_adr_i == CTRL_ADDR)
      begin
        ctrl_w = lane_merge(ctrl_w, wb_dat_i, wb_sel_i);
        state_next.soft_mute = ctrl_w[CTRL_SOFT_MUTE_BIT];
        state_next.auto_mute = ctrl_w[CTRL_AUTO_MUTE_BIT];
        state_next.deemph_sel = ctrl_w[CTRL_DEEMPH_LSB +: 2];
      end
      else if (wb_adr_i == TONE_ADDR)
      begin
        tone_w = lane_merge(tone_w, wb_dat_i, wb_sel_i);
        state_next.volume = tone_w[TONE_VOL_LSB +: 6];
        state_next.bass = tone_w[TONE_BASS_LSB +: 4];
        state_next.treble = tone_w[TONE_TREB_LSB +: 2];
        state_next.tone_mode = tone_w[TONE_MODE_LSB +: 2];
      end
    end

    state_next.pll_lock = pll_lock_i;
    state_next.dec_lock = decoder_lock_i;
    // lock pin needs both locks and PCM
    // low on non-PCM or no lock
    state_next.lock = pll_lock_i & decoder_lock_i & ~state_reg.non_pcm;

    // sample period must fit the rate window
    if (state_reg.period_cnt != PERIOD_SAT)
      state_next.period_cnt = state_reg.period_cnt + 11'h001;
    if (frame_valid_i)
    begin
      state_next.period_cnt = 11'h001;
      state_next.period = state_reg.period_cnt;
      state_next.rate_ok = (state_reg.period_cnt >= PERIOD_MIN) && (state_reg.period_cnt <= PERIOD_MAX);
    end

    // gather channel status bits per block
    if (frame_valid_i)
    begin
      idx = block_start_i ? 8'h00 : ((state_reg.cs_idx == 8'hFF) ? 8'hFF : state_reg.cs_idx + 8'h01);
      state_next.cs_idx = idx;
      cs_new = state_reg.cs_word;
      if (idx <= CS_LAST_BIT)
        cs_new[idx[4:0]] = cs_bit_i;
      state_next.cs_word = cs_new;
      if (idx == CS_LAST_BIT)
      begin
        state_next.non_pcm = cs_new[CS_NONPCM_BIT];
        state_next.preemph = cs_new[CS_PREEMPH_LSB +: 3];
        state_next.fs_code = cs_new[CS_FS_LSB +: 4];
        state_next.accuracy = cs_new[CS_ACC_LSB +: 2];
      end
    end

    // Static mode keeps serial defaults except de-emphasis
    if (static_pin_mode_select_i)
    begin
      if (state_reg.preemph != CS_PREEMPH_50_15)
        de_sel = DE_OFF;
      else if (state_reg.fs_code == CS_FS_32K)
        de_sel = DE_32K;
      else if (state_reg.fs_code == CS_FS_48K)
        de_sel = DE_48K;
      else
        de_sel = DE_44K1;
      mode = TONE_FLAT;
      vol = 6'h00;
      bass = 4'h0;
      treb = 2'h0;
    end
    else
    begin
      de_sel = state_reg.deemph_sel;
      mode = state_reg.tone_mode;
      vol = state_reg.volume;
      bass = state_reg.bass;
      treb = state_reg.treble;
    end
    sh = deemph_shift(de_sel);
    gain = ramp_gain(MUTE_STEPS - state_reg.mute_step);

    if (frame_valid_i)
    begin
      // ramp of 32 steps, each 32 samples
      case (state_reg.mstate)
        M_PLAY:
          if (mute_req)
            state_next.mstate = M_FALL;
        M_FALL:
          if (!mute_req)
            state_next.mstate = M_RISE;
          else
          begin
            state_next.mute_sub = state_reg.mute_sub + 5'h01;
            if (state_reg.mute_sub == MUTE_SUB_LAST)
            begin
              state_next.mute_step = state_reg.mute_step + 6'h01;
              if (state_reg.mute_step == MUTE_STEPS - 6'h01)
                state_next.mstate = M_SILENT;
            end
          end
        M_SILENT:
          if (!mute_req)
            state_next.mstate = M_RISE;
        M_RISE:
          // A ramp that has not yet left full attenuation returns to silence, so the step count cannot overrun
          if (mute_req)
            state_next.mstate = (state_reg.mute_step == MUTE_STEPS) ? M_SILENT : M_FALL;
          else
          begin
            state_next.mute_sub = state_reg.mute_sub + 5'h01;
            if (state_reg.mute_sub == MUTE_SUB_LAST)
            begin
              state_next.mute_step = state_reg.mute_step - 6'h01;
              if (state_reg.mute_step == 6'h01)
                state_next.mstate = M_PLAY;
            end
          end
        default:
          state_next.mstate = M_PLAY;
      endcase

      for (int ch = 0; ch < 2; ch++)
      begin
        x = longint'($signed(ch == 0 ? frame_left_i : frame_right_i));
        if (sh != 0)
        begin
          lp = longint'($signed(state_reg.lp_de[ch]));
          y = lp + ((x - lp) >>> sh);
        end
        else
          y = x;
        state_next.lp_de[ch] = sat24(y);
        // flat, minimum and maximum tone modes
        lp = longint'($signed(state_reg.lp_bass[ch]));
        lp = lp + ((y - lp) >>> BASS_LP_SHIFT);
        state_next.lp_bass[ch] = sat24(lp);
        if (mode == TONE_MAX)
          y = y + ((lp * longint'(bass)) >>> 3);
        else if (mode == TONE_MIN)
          y = y + ((lp * longint'(bass)) >>> 4);
        lp = longint'($signed(state_reg.lp_treb[ch]));
        lp = lp + ((y - lp) >>> TREB_LP_SHIFT);
        state_next.lp_treb[ch] = sat24(lp);
        if (mode == TONE_MAX)
          y = y + (((y - lp) * longint'(treb)) >>> 1);
        else if (mode == TONE_MIN)
          y = y + (((y - lp) * longint'(treb)) >>> 2);
        y = (y * (64 - longint'(vol))) >>> 6;
        y = (y * gain) >>> 16;
        state_next.smp[ch] = hard_mute ? 24'h000000 : sat24(y);
      end
    end

    // 128fs tick derived from the measured sample period
    state_next.strobe = 1'b0;
    if (state_reg.os_cnt <= OS_RELOAD_MIN)
    begin
      state_next.os_cnt = (state_reg.period >> OS_SHIFT) > OS_RELOAD_MIN ?
                          (state_reg.period >> OS_SHIFT) : OS_RELOAD_MIN + 11'h001;
      state_next.strobe = 1'b1;
      for (int ch = 0; ch < 2; ch++)
      begin
        lp = longint'($signed(state_reg.rec[ch]));
        lp = lp + ((longint'($signed(state_reg.smp[ch])) - lp) >>> REC_SHIFT);
        state_next.rec[ch] = sat24(lp);
        state_next.rec_d[ch] = state_reg.rec[ch];
        x = (lp + longint'($signed(state_reg.rec[ch]))) >>> 1;
        fb = state_reg.bits[ch] ? 64'sd8388608 : -64'sd8388608;
        y = longint'($signed(state_reg.ns1[ch])) + x - fb;
        state_next.ns1[ch] = sat28(y);
        y = longint'($signed(state_reg.ns2[ch])) + (y >>> 1) - fb;
        state_next.ns2[ch] = sat28(y);
        y = longint'($signed(state_reg.ns3[ch])) + (y >>> 2) - fb;
        state_next.ns3[ch] = sat28(y);
        state_next.bits[ch] = (y >= 0);
      end
    end
    else
      state_next.os_cnt = state_reg.os_cnt - 11'h001;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
      state_reg.soft_mute <= CTRL_RESET[CTRL_SOFT_MUTE_BIT];
      state_reg.auto_mute <= CTRL_RESET[CTRL_AUTO_MUTE_BIT];
      state_reg.mstate <= M_SILENT;
      state_reg.mute_step <= MUTE_STEPS;
      state_reg.period_cnt <= PERIOD_SAT;
      state_reg.cs_idx <= 8'hFF;
    end
    else
      state_reg <= state_next;
  end

  assign wb_dat_o = state_reg.dat;
  assign wb_ack_o = state_reg.ack;
  assign lock_o = state_reg.lock;
  assign stream_left_o = state_reg.bits[0];
  assign stream_right_o = state_reg.bits[1];
  assign stream_strobe_o = state_reg.strobe;

  property p_lock_high;
    @(posedge clock_i) disable iff (rst_i)
    (!rst_i && pll_lock_i && decoder_lock_i && !state_reg.non_pcm) |=> lock_o;
  endproperty
  a_lock_high: assert property (p_lock_high) else $error("lock pin not raised");

  property p_lock_low;
    @(posedge clock_i) disable iff (rst_i)
    (state_reg.non_pcm || !pll_lock_i || !decoder_lock_i) |=> !lock_o;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock pin not dropped");

  property p_pll_bit;
    @(posedge clock_i) disable iff (rst_i)
    (!rst_i && pll_lock_i) ##1 pll_lock_i |-> state_reg.pll_lock;
  endproperty
  a_pll_bit: assert property (p_pll_bit) else $error("clock lock bit missing");

  property p_mute_pin;
    @(posedge clock_i) disable iff (rst_i)
    (static_pin_mode_select_i && mute_pin_i && frame_valid_i)
      |=> (state_reg.mstate == M_FALL || state_reg.mstate == M_SILENT);
  endproperty
  a_mute_pin: assert property (p_mute_pin) else $error("mute pin ignored");

  property p_ramp_end;
    @(posedge clock_i) disable iff (rst_i)
    (frame_valid_i && mute_req && state_reg.mstate == M_FALL && state_reg.mute_step == 6'h1F
      && state_reg.mute_sub == 5'h1F) |=> (state_reg.mstate == M_SILENT && state_reg.mute_step == 6'h20);
  endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("ramp length wrong");

  property p_reset_mute;
    @(posedge clock_i)
    $fell(rst_i) |-> (state_reg.soft_mute && state_reg.mstate == M_SILENT);
  endproperty
  a_reset_mute: assert property (p_reset_mute) else $error("not muted after reset");

  property p_pin_ignored;
    @(posedge clock_i) disable iff (rst_i)
    (!static_pin_mode_select_i && !state_reg.soft_mute && frame_valid_i)
      |=> state_reg.mstate != M_FALL;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("mute pin acted in serial mode");

  property p_hard_zero;
    @(posedge clock_i) disable iff (rst_i)
    (frame_valid_i && hard_mute) |=> (state_reg.smp[0] == 24'h000000 && state_reg.smp[1] == 24'h000000);
  endproperty
  a_hard_zero: assert property (p_hard_zero) else $error("sample not zeroed unlocked");

  property p_strobe_gap;
    @(posedge clock_i) disable iff (rst_i)
    stream_strobe_o |=> !stream_strobe_o;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("bit strobe too close");

  c_ramp_done: cover property (@(posedge clock_i) disable iff (rst_i) state_reg.mstate == M_SILENT);
  c_play: cover property (@(posedge clock_i) disable iff (rst_i) state_reg.mstate == M_PLAY && lock_o);
  c_rise: cover property (@(posedge clock_i) disable iff (rst_i) state_reg.mstate == M_RISE);
  c_write: cover property (@(posedge clock_i) disable iff (rst_i) wb_ack_o && wb_we_i);

endmodule // iec958_lock_mute_audio_path

// ---- tb/iec958_source_model.sv ----
`timescale 1ns/10ps
module iec958_source_model
#(
  parameter int PERIOD = 800
)
(
  // Clock and control
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [31:0] cs_word_i,
  // Frame stream
  output logic frame_valid_o,
  output logic block_start_o,
  output logic cs_bit_o,
  output logic [23:0] left_o,
  output logic [23:0] right_o,
  output logic [7:0] blocks_o
);
  logic [10:0] gap;
  logic [4:0] idx;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      gap <= 11'h000;
      idx <= 5'h00;
      blocks_o <= 8'h00;
      frame_valid_o <= 1'b0;
      block_start_o <= 1'b0;
      cs_bit_o <= 1'b0;
      left_o <= 24'h000000;
      right_o <= 24'h000000;
    end
    else
    begin
      frame_valid_o <= 1'b0;
      block_start_o <= 1'b0;
      // Lines toggle between frames so stale data is never mistaken for valid
      left_o <= ~left_o;
      right_o <= ~right_o;
      cs_bit_o <= ~cs_bit_o;
      if (run_i)
      begin
        // frame spacing inside the accepted rate window
        if (gap == 11'(PERIOD - 1))
        begin
          gap <= 11'h000;
          frame_valid_o <= 1'b1;
          block_start_o <= (idx == 5'h00);
          cs_bit_o <= cs_word_i[idx];
          left_o <= 24'h123400 + 24'(idx);
          right_o <= 24'hABC000 ^ 24'(idx);
          idx <= idx + 5'h01;
          if (idx == 5'h1F)
          begin
            blocks_o <= blocks_o + 8'h01;
          end
        end
        else
        begin
          gap <= gap + 11'h001;
        end
      end
    end
  end
endmodule // iec958_source_model

// ---- tb/tb_iec958_lock_mute_audio_path.sv ----
`timescale 1ns/10ps
module tb_iec958_lock_mute_audio_path;
  import iec958_audio_pkg::*;
  // 62.5 kHz: a whole number of 128fs ticks per sample period
  localparam int PERIOD = 640;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, lock_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic frame_valid_i, cs_bit_i, block_start_i, stream_left_o, stream_right_o, stream_strobe_o;
  logic [23:0] frame_left_i, frame_right_i;
  logic decoder_lock_i = 1'b1, pll_lock_i = 1'b1, static_pin_mode_select_i = 1'b0, mute_pin_i = 1'b0;
  logic run = 1'b1;
  logic [31:0] cs_word = 32'h2300_0008;
  logic [7:0] blocks;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  int o;

  initial forever #12.5 clock_i = ~clock_i;

  iec958_lock_mute_audio_path iec958_lock_mute_audio_path_inst (.clock_i(clock_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_valid_i(frame_valid_i),
    .frame_left_i(frame_left_i), .frame_right_i(frame_right_i), .cs_bit_i(cs_bit_i),
    .block_start_i(block_start_i), .decoder_lock_i(decoder_lock_i), .pll_lock_i(pll_lock_i),
    .static_pin_mode_select_i(static_pin_mode_select_i), .mute_pin_i(mute_pin_i), .lock_o(lock_o),
    .stream_left_o(stream_left_o), .stream_right_o(stream_right_o), .stream_strobe_o(stream_strobe_o));

  iec958_source_model #(.PERIOD(PERIOD)) iec958_source_model_inst (.clock_i(clock_i), .rst_i(rst_i),
    .run_i(run), .cs_word_i(cs_word), .frame_valid_o(frame_valid_i), .block_start_o(block_start_i),
    .cs_bit_o(cs_bit_i), .left_o(frame_left_i), .right_o(frame_right_i), .blocks_o(blocks));

  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 50)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'h0);
    chk(name, r & mask, exp);
  endtask

  task automatic wait_block;
    int k;
    logic [7:0] target;
    target = blocks + 8'h01;
    k = 0;
    while (blocks !== target && k < 40000)
    begin
      @(posedge clock_i);
      k++;
    end
    repeat (4) @(posedge clock_i);
    if (k >= 40000)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    rd_chk("ctrl reset", CTRL_ADDR, 32'hFFFF_FFFF, CTRL_RESET);
    rd_chk("tone reset", TONE_ADDR, 32'hFFFF_FFFF, TONE_RESET);
    for (int m = 0; m < 3; m++)
    begin
      wb(1'b1, TONE_ADDR, 32'hFFC3_FFFF | (32'(m) << TONE_MODE_LSB), 4'hF);
      rd_chk("tone fields", TONE_ADDR, 32'hFFFF_FFFF, 32'h0003_0F3F | (32'(m) << TONE_MODE_LSB));
    end
    for (int d = 0; d < 4; d++)
    begin
      wb(1'b1, CTRL_ADDR, 32'h3 | (32'(d) << CTRL_DEEMPH_LSB), 4'hF);
      rd_chk("deemphasis", CTRL_ADDR, 32'hFFFF_FFFF, 32'h3 | (32'(d) << CTRL_DEEMPH_LSB));
    end
    // Only lane 1 enabled, so the control byte must survive
    wb(1'b1, CTRL_ADDR, 32'h0, 4'h2);
    rd_chk("byte lane", CTRL_ADDR, 32'hFFFF_FFFF, 32'hF);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
    rd_chk("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0);
    // Release the start-up soft mute; the pin is raised but must not matter in serial mode
    wb(1'b1, CTRL_ADDR, 32'h2, 4'hF);
    mute_pin_i <= 1'b1;
    wait_block();
    rd_chk("status pcm", STATUS_ADDR, 32'h3FF7, 32'h2337);
    chk("lock pcm", {31'h0, lock_o}, 32'h1);
    n = 0;
    o = 0;
    repeat (PERIOD)
    begin
      @(posedge clock_i);
      n += (stream_strobe_o === 1'b1) ? 1 : 0;
      o += (stream_strobe_o === 1'b1 && stream_left_o === 1'b1) ? 1 : 0;
      o += (stream_strobe_o === 1'b1 && stream_right_o === 1'b1) ? 1 : 0;
    end
    chk("strobe rate", n, 32'd128);
    chk("stream toggles", {31'h0, (o > 0 && o < 2 * n)}, 32'h1);
    cs_word <= 32'h2300_000A;
    wait_block();
    chk("lock nonpcm", {31'h0, lock_o}, 32'h0);
    rd_chk("status nonpcm", STATUS_ADDR, 32'h3FF7, 32'h2333);
    cs_word <= 32'h2300_0008;
    wait_block();
    chk("lock back", {31'h0, lock_o}, 32'h1);
    wb(1'b0, SAMPLE_ADDR, 32'h0, 4'h0);
    chk("sample live", {31'h0, (r[23:0] != 24'h000000)}, 32'h1);
    pll_lock_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("lock lost", {31'h0, lock_o}, 32'h0);
    repeat (PERIOD + 5) @(posedge clock_i);
    rd_chk("hard mute", SAMPLE_ADDR, 32'h00FF_FFFF, 32'h0);
    rd_chk("pll bit", STATUS_ADDR, 32'h1, 32'h0);
    wb(1'b1, CTRL_ADDR, 32'h0, 4'hF);
    repeat (PERIOD + 5) @(posedge clock_i);
    wb(1'b0, SAMPLE_ADDR, 32'h0, 4'h0);
    chk("auto mute off", {31'h0, (r[23:0] != 24'h000000)}, 32'h1);
    // Static mode with the pin raised lets the pin-driven mute assertion see frames
    static_pin_mode_select_i <= 1'b1;
    repeat (PERIOD + 5) @(posedge clock_i);
    finish_test();
  end
endmodule // tb_iec958_lock_mute_audio_path
